// ---- hw/dpmc_pkg.sv ----
// shared constants and types for the debug power mode control block
package dpmc_pkg;
    localparam int DPMC_N_CONS = 4;
    localparam int DPMC_PRIO_W = 3;
    localparam int DPMC_SYNC_STAGES = 2;
    localparam logic DPMC_FLAG_RESET = 1'b0;
    localparam logic DPMC_MODE_RESET = 1'b0;
    localparam logic [DPMC_PRIO_W-1:0] DPMC_PRIO_NONE = 3'h7;

    typedef enum logic [2:0] {
        DPMC_ST_OFF = 3'h1,
        DPMC_ST_WAKE = 3'h2,
        DPMC_ST_RUN = 3'h4
    } dpmc_state_t;

    localparam dpmc_state_t DPMC_ST_RESET = DPMC_ST_RUN;
endpackage : dpmc_pkg

// ---- hw/dpmc_power_manager.sv ----
// demand-driven regulator and clock source control
`timescale 1ns/1ps
`default_nettype none
module dpmc_power_manager
    import dpmc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset, active low
    input wire logic i_sys_on, // system is on
    input wire logic i_force_on, // debug mode keeps everything running
    input wire logic [DPMC_N_CONS-1:0] i_pwr_demand, // per consumer power request
    input wire logic [DPMC_N_CONS-1:0] i_clk_demand, // per consumer clock request
    input wire logic [DPMC_N_CONS-1:0] i_hp_demand, // per consumer full-power request
    output logic o_reg_en, // regulator enable
    output logic o_reg_hp, // regulator in full-power mode
    output logic o_clk_en // high frequency clock source enable
);
    wire logic [DPMC_N_CONS-1:0] pwr_eff;
    wire logic [DPMC_N_CONS-1:0] clk_eff;
    wire logic [DPMC_N_CONS-1:0] hp_eff;
    logic reg_en_reg;
    logic reg_hp_reg;
    logic clk_en_reg;
    wire logic reg_en_next;
    wire logic reg_hp_next;
    wire logic clk_en_next;

    // a clock or full-power request implies power for that consumer
    genvar g;
    generate
        for (g = 0; g < DPMC_N_CONS; g++) begin : g_cons
            assign pwr_eff[g] = i_pwr_demand[g] | i_clk_demand[g] | i_hp_demand[g];
            assign clk_eff[g] = i_clk_demand[g];
            assign hp_eff[g] = i_hp_demand[g];
        end
    endgenerate

    // debug mode costs power on purpose: the debugger must see a running core
    assign reg_en_next = i_sys_on & ((|pwr_eff) | i_force_on);
    assign reg_hp_next = i_sys_on & ((|hp_eff) | i_force_on);
    assign clk_en_next = i_sys_on & ((|clk_eff) | i_force_on);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_en_reg <= 1'b0;
            reg_hp_reg <= 1'b0;
            clk_en_reg <= 1'b0;
        end else begin
            reg_en_reg <= reg_en_next;
            reg_hp_reg <= reg_hp_next;
            clk_en_reg <= clk_en_next;
        end
    end

    assign o_reg_en = reg_en_reg;
    assign o_reg_hp = reg_hp_reg;
    assign o_clk_en = clk_en_reg;
endmodule : dpmc_power_manager
`default_nettype wire

// ---- hw/dpmc_top.sv ----
// debug power request handling, debug mode flag, wake and access gating
// How it works
// - request while system off wakes system and sets debug wake flag
// - debug mode flag stays set while request is held
// - dropping the request clears debug mode, back to normal
// - debug mode flag is an output for peripherals
// - higher priority interrupts keep running while lower code is halted
// - power manager switches regulator and clock by consumer demand
`timescale 1ns/1ps
`default_nettype none
module dpmc_top
    import dpmc_pkg::*;
(
    input wire logic I_CLK, // system clock, 250 MHz
    input wire logic I_RSTN, // asynchronous reset, active low
    input wire logic I_DBG_CLK, // serial debug port clock
    input wire logic I_DBG_PWR_REQ, // debug_power_request from link, link domain
    input wire logic I_AP_REQ, // access request from link, link domain
    input wire logic I_AP_SEL, // 0 cpu_bus_access_port, 1 control_access_port
    output logic O_DBG_PWR_ACK, // power acknowledge, link domain
    output logic O_CPU_AP_GRANT, // cpu_bus_access_port access granted
    output logic O_CONTROL_ACCESS_PORT_GRANT, // control_access_port access granted
    output logic O_AP_DENY, // access refused, no power request or no power acknowledge
    input wire logic I_SYSOFF_REQ, // cpu asks to enter system off, pulse
    input wire logic I_REASON_CLR, // clear debug_wake_flag, pulse
    output logic O_SYS_ON, // system powered
    output logic O_SYS_WAKE, // wake pulse out of system off
    output logic O_DEBUG_MODE, // debug interface mode for peripherals
    output logic O_DEBUG_WAKE_FLAG, // debug_wake_flag of reset_reason_record
    input wire logic I_HALTED, // core halted at breakpoint or step
    input wire logic [DPMC_PRIO_W-1:0] I_HALT_PRIO, // priority of halted context
    input wire logic [DPMC_PRIO_W-1:0] I_IRQ_PRIO, // priority of pending interrupt
    input wire logic I_IRQ_PEND, // interrupt pending
    output logic O_IRQ_RUN, // pending interrupt may run
    input wire logic [DPMC_N_CONS-1:0] I_PWR_DEMAND, // consumer power requests
    input wire logic [DPMC_N_CONS-1:0] I_CLK_DEMAND, // consumer clock requests
    input wire logic [DPMC_N_CONS-1:0] I_HP_DEMAND, // consumer full-power requests
    output logic O_REG_EN, // regulator enable
    output logic O_REG_HP, // regulator full-power mode
    output logic O_CLK_EN // clock source enable
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release, one copy per domain
    logic [1:0] rst_sync_reg;
    logic [1:0] lrst_sync_reg;
    wire logic rst_n;
    wire logic lrst_n;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    always_ff @(posedge I_DBG_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            lrst_sync_reg <= 2'h0;
        end else begin
            lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];
    assign lrst_n = lrst_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // link domain: request latch, acknowledge sync, access gating
    // system domain mode flag, declared early since the link side samples it
    logic mode_reg;
    logic req_link_reg;
    logic [1:0] ack_sync_reg;
    logic cpu_grant_reg;
    logic ctrl_grant_reg;
    logic deny_reg;
    wire logic ack_l;
    wire logic grant_ok;

    assign ack_l = ack_sync_reg[1];
    // grants only after the power-up handshake has closed
    assign grant_ok = I_AP_REQ & ack_l & req_link_reg;

    always_ff @(posedge I_DBG_CLK or negedge lrst_n) begin
        if (!lrst_n) begin
            req_link_reg <= 1'b0;
            ack_sync_reg <= 2'h0;
            cpu_grant_reg <= 1'b0;
            ctrl_grant_reg <= 1'b0;
            deny_reg <= 1'b0;
        end else begin
            req_link_reg <= I_DBG_PWR_REQ;
            ack_sync_reg <= {ack_sync_reg[0], mode_reg};
            cpu_grant_reg <= grant_ok & ~I_AP_SEL;
            ctrl_grant_reg <= grant_ok & I_AP_SEL;
            deny_reg <= I_AP_REQ & ~grant_ok;
        end
    end

    assign O_DBG_PWR_ACK = ack_l;
    assign O_CPU_AP_GRANT = cpu_grant_reg;
    assign O_CONTROL_ACCESS_PORT_GRANT = ctrl_grant_reg;
    assign O_AP_DENY = deny_reg;

    ////////////////////////////////////////////////////////////////////////////
    // system domain: request sync, mode flag, wake machine
    logic [1:0] req_sync_reg;
    logic flag_reg;
    dpmc_state_t state_reg;
    dpmc_state_t state_next;
    wire logic req_s;
    wire logic wake_hit;
    wire logic flag_next;

    assign req_s = req_sync_reg[1];
    assign wake_hit = (state_reg == DPMC_ST_OFF) & req_s;
    // a new wake beats a clear in the same cycle
    assign flag_next = wake_hit | (flag_reg & ~I_REASON_CLR);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            DPMC_ST_OFF: begin
                if (req_s) begin
                    state_next = DPMC_ST_WAKE;
                end
            end
            DPMC_ST_WAKE: begin
                state_next = DPMC_ST_RUN;
            end
            DPMC_ST_RUN: begin
                // system off refused while a debugger holds power
                if (I_SYSOFF_REQ && !req_s) begin
                    state_next = DPMC_ST_OFF;
                end
            end
            default: begin
                state_next = DPMC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            req_sync_reg <= 2'h0;
            mode_reg <= DPMC_MODE_RESET;
            flag_reg <= DPMC_FLAG_RESET;
            state_reg <= DPMC_ST_RESET;
        end else begin
            req_sync_reg <= {req_sync_reg[0], req_link_reg};
            mode_reg <= req_s;
            flag_reg <= flag_next;
            state_reg <= state_next;
        end
    end

    assign O_SYS_ON = (state_reg != DPMC_ST_OFF);
    assign O_SYS_WAKE = (state_reg == DPMC_ST_WAKE);
    assign O_DEBUG_MODE = mode_reg;
    assign O_DEBUG_WAKE_FLAG = flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    // real-time debug: lower number means higher priority
    wire logic irq_beats_halt;
    assign irq_beats_halt = (I_IRQ_PRIO < I_HALT_PRIO);
    assign O_IRQ_RUN = I_IRQ_PEND & (~I_HALTED | irq_beats_halt);

    ////////////////////////////////////////////////////////////////////////////
    // power manager
    dpmc_power_manager u_pm (
        .clk(I_CLK),
        .rst_n(rst_n),
        .i_sys_on(O_SYS_ON),
        .i_force_on(mode_reg),
        .i_pwr_demand(I_PWR_DEMAND),
        .i_clk_demand(I_CLK_DEMAND),
        .i_hp_demand(I_HP_DEMAND),
        .o_reg_en(O_REG_EN),
        .o_reg_hp(O_REG_HP),
        .o_clk_en(O_CLK_EN)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence off_with_req_s;
        (state_reg == DPMC_ST_OFF) && req_s;
    endsequence

    sequence wake_then_run_s;
        (state_reg == DPMC_ST_WAKE) ##1 (state_reg == DPMC_ST_RUN);
    endsequence

    wake_on_req_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        off_with_req_s |=> wake_then_run_s)
        else $error("request in system off did not wake the system");

    wake_flag_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        off_with_req_s |=> O_DEBUG_WAKE_FLAG && O_SYS_WAKE)
        else $error("debug wake flag not set on wake");

    flag_set_wins_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (wake_hit && I_REASON_CLR) |=> O_DEBUG_WAKE_FLAG)
        else $error("clear beat a wake in the same cycle");

    mode_held_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        req_s [*2] |-> O_DEBUG_MODE)
        else $error("debug mode dropped while request held");

    mode_leave_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        $fell(req_s) |=> !O_DEBUG_MODE)
        else $error("debug mode kept after request withdrawn");

    rt_irq_run_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (I_HALTED && I_IRQ_PEND) |-> (O_IRQ_RUN == (I_IRQ_PRIO < I_HALT_PRIO)))
        else $error("interrupt priority gating wrong while halted");

    pm_demand_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (O_SYS_ON && (|I_CLK_DEMAND)) |=> (O_CLK_EN && O_REG_EN))
        else $error("clock demand not served");

    pm_idle_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (!O_SYS_ON || (!mode_reg && !(|I_PWR_DEMAND) && !(|I_CLK_DEMAND)
            && !(|I_HP_DEMAND))) |=> !O_CLK_EN && !O_REG_EN)
        else $error("resources kept on without demand");

    ap_gate_a: assert property (@(posedge I_DBG_CLK) disable iff (!lrst_n)
        $rose(O_CPU_AP_GRANT || O_CONTROL_ACCESS_PORT_GRANT) |-> $past(ack_l))
        else $error("access granted without power acknowledge");

    sequence sysoff_taken_s;
        (state_reg == DPMC_ST_RUN) && I_SYSOFF_REQ && !req_s;
    endsequence

    sequence sysoff_held_s;
        (state_reg == DPMC_ST_RUN) && I_SYSOFF_REQ && req_s;
    endsequence

    sysoff_enter_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        sysoff_taken_s |=> !O_SYS_ON)
        else $error("system off request not taken in normal mode");

    sysoff_refused_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        sysoff_held_s |=> O_SYS_ON)
        else $error("system went off while debugger held power");

    wake_pulse_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        O_SYS_WAKE |-> (O_SYS_ON ##1 !O_SYS_WAKE))
        else $error("wake pulse longer than one cycle or system not on");

    flag_sticky_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (O_DEBUG_WAKE_FLAG && !I_REASON_CLR) |=> O_DEBUG_WAKE_FLAG)
        else $error("debug wake flag lost without clear");

    flag_clear_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (I_REASON_CLR && !wake_hit) |=> !O_DEBUG_WAKE_FLAG)
        else $error("debug wake flag not cleared");

    flag_source_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        $rose(O_DEBUG_WAKE_FLAG) |-> $past(wake_hit))
        else $error("debug wake flag set without a debug wake");

    mode_rise_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        $rose(req_s) |=> O_DEBUG_MODE)
        else $error("debug mode not entered on request");

    mode_quiet_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (!req_s) [*2] |-> !O_DEBUG_MODE)
        else $error("debug mode set without request");

    pm_force_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (O_SYS_ON && O_DEBUG_MODE) |=> (O_REG_EN && O_REG_HP && O_CLK_EN))
        else $error("debug mode did not keep resources on");

    pm_sys_off_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        !O_SYS_ON |=> (!O_REG_HP && !O_CLK_EN))
        else $error("resources on in system off");

    irq_free_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (I_IRQ_PEND && !I_HALTED) |-> O_IRQ_RUN)
        else $error("interrupt blocked while core not halted");

    irq_idle_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        !I_IRQ_PEND |-> !O_IRQ_RUN)
        else $error("interrupt run without pending interrupt");

    grant_onehot_a: assert property (@(posedge I_DBG_CLK) disable iff (!lrst_n)
        $onehot0({O_CPU_AP_GRANT, O_CONTROL_ACCESS_PORT_GRANT, O_AP_DENY}))
        else $error("more than one access answer at once");

    deny_no_ack_a: assert property (@(posedge I_DBG_CLK) disable iff (!lrst_n)
        (I_AP_REQ && !ack_l) |=> O_AP_DENY)
        else $error("access without power acknowledge not refused");

    link_quiet_a: assert property (@(posedge I_DBG_CLK) disable iff (!lrst_n)
        !I_AP_REQ |=> !(O_CPU_AP_GRANT || O_CONTROL_ACCESS_PORT_GRANT || O_AP_DENY))
        else $error("access answer without access request");

    grant_ctrl_a: assert property (@(posedge I_DBG_CLK) disable iff (!lrst_n)
        (I_AP_REQ && ack_l && req_link_reg && I_AP_SEL) |=> O_CONTROL_ACCESS_PORT_GRANT)
        else $error("control port access not granted");
endmodule : dpmc_top
`default_nettype wire

// ---- verification/dpmc_dbg_model.sv ----
// debugger model driving the serial debug link
`timescale 1ns/1ps
`default_nettype none
module dpmc_dbg_model (
    output logic o_clk, // link clock, stands still after a power off until the next task starts it
    output logic o_pwr_req, // debug_power_request
    output logic o_ap_req, // access request
    output logic o_ap_sel, // 0 cpu port, 1 control port
    input wire logic i_cpu_grant, // cpu_bus_access_port grant
    input wire logic i_ctrl_grant, // control_access_port grant
    input wire logic i_deny // access refused
);
    logic run = 1'b1;
    initial begin
        o_clk = 1'b0;
        o_pwr_req = 1'b0;
        o_ap_req = 1'b0;
        o_ap_sel = 1'b0;
        #1.3;
        forever begin
            #7.5;
            // only stops on a low phase
            if (run || o_clk) o_clk = ~o_clk;
        end
    end
    task automatic power(input logic on, input int cycles);
        run = 1'b1;
        @(posedge o_clk);
        o_pwr_req <= on;
        repeat (cycles) @(posedge o_clk);
        if (!on) run = 1'b0;
    endtask : power
    task automatic access(input logic sel, output logic [2:0] seen);
        run = 1'b1;
        @(posedge o_clk);
        o_ap_req <= 1'b1;
        o_ap_sel <= sel;
        @(posedge o_clk);
        o_ap_req <= 1'b0;
        // the answer stands for one link cycle only, so look at it now
        #1 seen = {i_cpu_grant, i_ctrl_grant, i_deny};
    endtask : access
endmodule : dpmc_dbg_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the debug power mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
    import dpmc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, sysoff = 1'b0, rclr = 1'b0, halted = 1'b0, pend = 1'b0;
    logic [2:0] hprio = 3'h0, iprio = 3'h0, seen;
    logic [3:0] pwr_d = 4'h0, clk_d = 4'h0, hp_d = 4'h0;
    logic dclk, preq, apreq, apsel, ack, cgr, tgr, deny, sys_on, wake, dmode, dflag, irq_run;
    logic reg_en, reg_hp, clk_en;
    int err_total = 0, n_tests = 0, cyc = 0, cnt;
    logic [10:0] irq_tab [5] = '{11'h1EA, 11'h0D5, 11'h0DB, 11'h187, 11'h078};
    always #2 clk = ~clk;
    dpmc_dbg_model u_dbg (.o_clk(dclk), .o_pwr_req(preq), .o_ap_req(apreq), .o_ap_sel(apsel),
        .i_cpu_grant(cgr), .i_ctrl_grant(tgr), .i_deny(deny));
    dpmc_top i_dut (.I_CLK(clk), .I_RSTN(rst_n), .I_DBG_CLK(dclk), .I_DBG_PWR_REQ(preq),
        .I_AP_REQ(apreq), .I_AP_SEL(apsel), .O_DBG_PWR_ACK(ack), .O_CPU_AP_GRANT(cgr),
        .O_CONTROL_ACCESS_PORT_GRANT(tgr), .O_AP_DENY(deny), .I_SYSOFF_REQ(sysoff), .I_REASON_CLR(rclr),
        .O_SYS_ON(sys_on), .O_SYS_WAKE(wake), .O_DEBUG_MODE(dmode), .O_DEBUG_WAKE_FLAG(dflag),
        .I_HALTED(halted), .I_HALT_PRIO(hprio), .I_IRQ_PRIO(iprio), .I_IRQ_PEND(pend),
        .O_IRQ_RUN(irq_run), .I_PWR_DEMAND(pwr_d), .I_CLK_DEMAND(clk_d), .I_HP_DEMAND(hp_d),
        .O_REG_EN(reg_en), .O_REG_HP(reg_hp), .O_CLK_EN(clk_en));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic wait_mode(input logic v);
        for (int i = 0; i < 40 && dmode !== v; i++) @(posedge clk);
        #1;
    endtask : wait_mode
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_session();
        u_dbg.access(1'b0, seen);
        `CHK("deny cpu", 3'b001, seen)
        u_dbg.power(1'b1, 6);
        wait_mode(1'b1);
        `CHK("mode on", 1'b1, dmode)
        u_dbg.access(1'b0, seen);
        `CHK("grant cpu", 3'b100, seen)
        `CHK("ack on", 1'b1, ack)
        u_dbg.access(1'b1, seen);
        `CHK("grant ctrl", 3'b010, seen)
        repeat (30) @(posedge clk);
        #1 `CHK("mode held", 1'b1, dmode)
        `CHK("forced hp", 1'b1, reg_hp)
        u_dbg.power(1'b0, 12);
        wait_mode(1'b0);
        `CHK("mode off", 1'b0, dmode)
        u_dbg.access(1'b1, seen);
        `CHK("deny after", 3'b001, seen)
        `CHK("ack off", 1'b0, ack)
        $display("test session done");
    endtask : t_session
    task automatic t_wake();
        @(posedge clk) sysoff <= 1'b1;
        @(posedge clk) sysoff <= 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK("sys off", 1'b0, sys_on)
        `CHK("reg off", 1'b0, reg_en)
        cnt = 0;
        u_dbg.power(1'b1, 0);
        for (int i = 0; i < 30; i++) begin
            @(posedge clk);
            #1 cnt += wake;
        end
        `CHK("wake pulses", 1, cnt)
        `CHK("wake flag", 1'b1, dflag)
        `CHK("sys on", 1'b1, sys_on)
        @(posedge clk) rclr <= 1'b1;
        @(posedge clk) rclr <= 1'b0;
        @(posedge clk);
        #1 `CHK("flag clear", 1'b0, dflag)
        @(posedge clk) sysoff <= 1'b1;
        @(posedge clk) sysoff <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("sys held on", 1'b1, sys_on)
        `CHK("mode through off", 1'b1, dmode)
        u_dbg.power(1'b0, 12);
        $display("test wake done");
    endtask : t_wake
    task automatic t_irq();
        foreach (irq_tab[k]) begin
            @(posedge clk) {pend, halted, hprio, iprio} <= irq_tab[k][7:0];
            #1 `CHK("irq run", irq_tab[k][8], irq_run)
        end
        $display("test irq done");
    endtask : t_irq
    task automatic t_demand();
        @(posedge clk) begin
            pwr_d <= 4'h2;
            clk_d <= 4'h1;
        end
        repeat (2) @(posedge clk);
        #1 `CHK("reg en", 3'b101, {reg_en, reg_hp, clk_en})
        @(posedge clk) hp_d <= 4'h8;
        repeat (2) @(posedge clk);
        #1 `CHK("reg hp", 1'b1, reg_hp)
        @(posedge clk) {pwr_d, clk_d, hp_d} <= 12'h000;
        repeat (2) @(posedge clk);
        #1 `CHK("all off", 3'b000, {reg_en, reg_hp, clk_en})
        $display("test demand done");
    endtask : t_demand
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1 `CHK("reset sys on", 1'b1, sys_on)
        `CHK("reset mode", 2'b00, {dmode, dflag})
        // link reset needs two link edges before the link clock may stop
        repeat (2) @(posedge dclk);
        u_dbg.run = 1'b0;
        t_session();
        t_wake();
        t_irq();
        t_demand();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
